// File: hdl/dac_ctrl_pkg.sv
// Purpose: constants for the two-channel converter control block
// Assumes: Avalon-MM word registers at byte address = 4 x register index
// Notes: conversion figures are cycle counts at the 10 MHz system clock
// What this block does
// R1: Without event triggering, a data register write starts that channel's conversion.
// R2: With event triggering, start only on the selected event with fresh data.
// R3: Two channels, each taking a 12-bit unsigned sample.
// R4: Each channel has its own data, control and output.
// R5: Linear code mapping; zero gives zero, 0xFFF gives the reference.
// R6: Channel 0 output can be routed internally to comparator and ADC.
// R7: All control logic and data registers run on the peripheral clock.
// R8: Low-power mode doubles each conversion time.
// R9: Software picks one of four references.
// R10: Offset trim is sign-magnitude, bit 7 sign, 1/64 to 1/4096 steps.
// R11: Gain trim scales deviation from mid-code, 1/16 to 1/1024 steps.
// R12: Calibrated output is raw output plus offset and gain corrections.
// R13: Software calibrates offset driving mid code 0x800.
// R14: Software calibrates gain driving code 0xFFF toward 4095/4096.
// R15: Calibrate with the final application configuration.
// R16: Data registers take writes from the DMA controller and the processor.
// R17: Channel select 00 ch0, 01 ch1, 10 both, 11 reserved.
// R18: Per-channel data-empty flag drives DMA request; late writes overwrite.
// R19: Three-bit event select; a fourth bit moves channel 1 one event up.
// R20: Data right-aligned by default; left-align moves it to upper bits.
// R21: Converted code holds on the output until the next conversion.
package dac_ctrl_pkg;
  // Register indices; byte address is four times these
  localparam logic [3:0] IDX_CTRL_A = 4'h0;
  localparam logic [3:0] IDX_CTRL_B = 4'h1;
  localparam logic [3:0] IDX_CTRL_C = 4'h2;
  localparam logic [3:0] IDX_EVENT_CTRL = 4'h3;
  localparam logic [3:0] IDX_STATUS = 4'h5;
  localparam logic [3:0] IDX_CHAN0_DATA = 4'h6;
  localparam logic [3:0] IDX_CHAN1_DATA = 4'h7;
  localparam logic [3:0] IDX_OFFSET_TRIM = 4'h8;
  localparam logic [3:0] IDX_GAIN_TRIM = 4'h9;
  // Control field positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_LOW_POWER = 1;
  localparam int BIT_CH0_OUT = 2;
  localparam int BIT_CH1_OUT = 3;
  localparam int BIT_INTERNAL_OUT = 4;
  localparam int BIT_CH0_TRIG = 0;
  localparam int BIT_CHANNEL_SELECT_LO = 5;
  localparam int BIT_LEFT_ALIGN = 0;
  localparam int BIT_REFSEL_LO = 3;
  localparam int BIT_TRIGGER_EVENT_SELECT_UP = 3;
  localparam int BIT_TRIM_SIGN = 7;
  // Channel select codes
  localparam logic [1:0] CHANNEL_SELECT_ONLY0 = 2'h0;
  localparam logic [1:0] CHANNEL_SELECT_ONLY1 = 2'h1;
  localparam logic [1:0] CHANNEL_SELECT_DUAL = 2'h2;
  // Reference codes
  localparam logic [1:0] REF_INT_1V = 2'h0;
  localparam logic [1:0] REF_ANALOG_SUPPLY = 2'h1;
  localparam logic [1:0] REF_PIN_PORT_A = 2'h2;
  localparam logic [1:0] REF_PIN_PORT_B = 2'h3;
  // Code range
  localparam logic [11:0] CODE_FULL = 12'hFFF;
  localparam logic [12:0] CODE_MID = 13'h0800;
  localparam int LEFT_SHIFT = 4;
  // Conversion timing
  localparam int CLK_MHZ = 10;
  localparam int CONV_TIME_NS = 1000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int LOW_POWER_FACTOR = 2;
  localparam logic [4:0] CONV_NORMAL = 5'(CONV_CYCLES);
  localparam logic [4:0] CONV_LOW = 5'(CONV_CYCLES * LOW_POWER_FACTOR);
endpackage

// File: hdl/dac_ctrl.sv
// Purpose: register file, conversion sequencing and trim arithmetic for two channels
// Assumes: event inputs are pulses from logic on sys_clk; data path is digital codes
// Notes: single-cycle writes, reads answer one cycle after the request
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module dac_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Event system channels
  input wire logic [7:0] eventIn,
  // DMA requests, one per channel
  output logic dmaRequest0,
  output logic dmaRequest1,
  // Converter outputs
  output logic [11:0] chan0Level,
  output logic [11:0] chan1Level,
  output logic chan0PinEnable,
  output logic chan1PinEnable,
  output logic internalRouteEnable,
  output logic [1:0] referenceSelect,
  output logic lowPowerSelect
);
  typedef struct packed {
    logic [4:0] ctrlA;
    logic [1:0] channelSelect;
    logic [1:0] trigMode;
    logic [1:0] refSel;
    logic leftAlign;
    logic [3:0] triggerEventSelect;
    logic [7:0] offsetTrim;
    logic [7:0] gainTrim;
    logic [1:0][11:0] sample;
    logic [1:0] pending;
    logic [1:0][11:0] inFlight;
    logic [1:0][4:0] convCount;
    logic [1:0][11:0] level;
    logic [31:0] readData;
    logic readValid;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic [1:0] chanOn;
  logic [1:0] chanEvent;
  logic [1:0] dataWrite;
  logic [1:0] startConv;
  logic [3:0] wIdx;
  logic [15:0] wLane;

  // Signed trims on the mid-code-referenced transfer
  function automatic logic [11:0] calibrate(logic [11:0] code, logic [7:0] offs,
                                           logic [7:0] gain);
    logic signed [13:0] dev;
    logic signed [21:0] prod;
    logic signed [14:0] gainTerm;
    logic signed [14:0] sum;
    dev = $signed({2'b00, code}) - $signed({1'b0, dac_ctrl_pkg::CODE_MID});
    prod = dev * $signed({1'b0, gain[6:0]});
    gainTerm = 15'(prod >>> 10);
    if (gain[dac_ctrl_pkg::BIT_TRIM_SIGN]) begin
      gainTerm = -gainTerm;
    end
    sum = $signed({3'b000, code}) + gainTerm; // R11
    if (offs[dac_ctrl_pkg::BIT_TRIM_SIGN]) begin
      sum = sum + $signed({8'h00, offs[6:0]}); // R10
    end else begin
      sum = sum - $signed({8'h00, offs[6:0]});
    end
    // Clamp: the analog range cannot exceed the rails
    if (sum < 0) begin
      calibrate = 12'h000;
    end else if (sum > $signed({3'b000, dac_ctrl_pkg::CODE_FULL})) begin
      calibrate = dac_ctrl_pkg::CODE_FULL;
    end else begin
      calibrate = sum[11:0]; // R12 R5
    end
  endfunction

  always_comb begin
    wIdx = avs_address[5:2];
    wLane = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // R17
    chanOn[0] = cur.ctrlA[dac_ctrl_pkg::BIT_ENABLE] &&
      (cur.channelSelect == dac_ctrl_pkg::CHANNEL_SELECT_ONLY0 ||
       cur.channelSelect == dac_ctrl_pkg::CHANNEL_SELECT_DUAL);
    chanOn[1] = cur.ctrlA[dac_ctrl_pkg::BIT_ENABLE] &&
      (cur.channelSelect == dac_ctrl_pkg::CHANNEL_SELECT_ONLY1 ||
       cur.channelSelect == dac_ctrl_pkg::CHANNEL_SELECT_DUAL);
    // R19
    chanEvent[0] = eventIn[cur.triggerEventSelect[2:0]];
    chanEvent[1] = cur.triggerEventSelect[dac_ctrl_pkg::BIT_TRIGGER_EVENT_SELECT_UP] ?
      eventIn[3'(cur.triggerEventSelect[2:0] + 3'h1)] :
      eventIn[cur.triggerEventSelect[2:0]];
    dataWrite[0] = avs_write && wIdx == dac_ctrl_pkg::IDX_CHAN0_DATA; // R16
    dataWrite[1] = avs_write && wIdx == dac_ctrl_pkg::IDX_CHAN1_DATA; // R16
    next_cur = cur;
    for (int c = 0; c < 2; c++) begin
      logic [15:0] raw;
      logic [15:0] merged;
      raw = cur.leftAlign ? {cur.sample[c], 4'h0} : {4'h0, cur.sample[c]};
      merged = (raw & ~wLane) | (avs_writedata[15:0] & wLane);
      // A start never shares a cycle with a write to the same channel
      startConv[c] = chanOn[c] && cur.pending[c] && cur.convCount[c] == 5'h00 &&
        !dataWrite[c] && (!cur.trigMode[c] || chanEvent[c]); // R1 R2 R4
      if (dataWrite[c]) begin
        next_cur.sample[c] = cur.leftAlign ? merged[15:4] : merged[11:0]; // R20 R3
        next_cur.pending[c] = 1'b1; // R18
      end else if (startConv[c]) begin
        next_cur.pending[c] = 1'b0;
        next_cur.inFlight[c] = cur.sample[c];
        next_cur.convCount[c] = cur.ctrlA[dac_ctrl_pkg::BIT_LOW_POWER] ?
          dac_ctrl_pkg::CONV_LOW : dac_ctrl_pkg::CONV_NORMAL; // R8
      end
      if (cur.convCount[c] != 5'h00) begin
        next_cur.convCount[c] = cur.convCount[c] - 5'h01;
        if (cur.convCount[c] == 5'h01) begin
          next_cur.level[c] = calibrate(cur.inFlight[c], cur.offsetTrim,
                                        cur.gainTrim); // R21
        end
      end
    end
    if (avs_write && avs_byteenable[0]) begin
      case (wIdx)
        dac_ctrl_pkg::IDX_CTRL_A: begin
          next_cur.ctrlA = avs_writedata[4:0];
        end
        dac_ctrl_pkg::IDX_CTRL_B: begin
          next_cur.channelSelect = avs_writedata[dac_ctrl_pkg::BIT_CHANNEL_SELECT_LO +: 2];
          next_cur.trigMode = avs_writedata[dac_ctrl_pkg::BIT_CH0_TRIG +: 2];
        end
        dac_ctrl_pkg::IDX_CTRL_C: begin
          next_cur.refSel = avs_writedata[dac_ctrl_pkg::BIT_REFSEL_LO +: 2];
          next_cur.leftAlign = avs_writedata[dac_ctrl_pkg::BIT_LEFT_ALIGN];
        end
        dac_ctrl_pkg::IDX_EVENT_CTRL: begin
          next_cur.triggerEventSelect = avs_writedata[3:0];
        end
        dac_ctrl_pkg::IDX_OFFSET_TRIM: begin
          next_cur.offsetTrim = avs_writedata[7:0];
        end
        dac_ctrl_pkg::IDX_GAIN_TRIM: begin
          next_cur.gainTrim = avs_writedata[7:0];
        end
        default: begin
        end
      endcase
    end
    next_cur.readValid = avs_read && !cur.readValid;
    if (avs_read && !cur.readValid) begin
      case (wIdx)
        dac_ctrl_pkg::IDX_CTRL_A: next_cur.readData = {27'h0, cur.ctrlA};
        dac_ctrl_pkg::IDX_CTRL_B: next_cur.readData = {25'h0, cur.channelSelect,
                                                      3'h0, cur.trigMode};
        dac_ctrl_pkg::IDX_CTRL_C: next_cur.readData = {27'h0, cur.refSel, 2'h0,
                                                      cur.leftAlign};
        dac_ctrl_pkg::IDX_EVENT_CTRL: next_cur.readData = {28'h0, cur.triggerEventSelect};
        dac_ctrl_pkg::IDX_STATUS: next_cur.readData = {30'h0, chanOn & ~cur.pending};
        dac_ctrl_pkg::IDX_CHAN0_DATA: next_cur.readData = cur.leftAlign ?
          {16'h0, cur.sample[0], 4'h0} : {20'h0, cur.sample[0]};
        dac_ctrl_pkg::IDX_CHAN1_DATA: next_cur.readData = cur.leftAlign ?
          {16'h0, cur.sample[1], 4'h0} : {20'h0, cur.sample[1]};
        dac_ctrl_pkg::IDX_OFFSET_TRIM: next_cur.readData = {24'h0, cur.offsetTrim};
        dac_ctrl_pkg::IDX_GAIN_TRIM: next_cur.readData = {24'h0, cur.gainTrim};
        default: next_cur.readData = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin // R7
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign avs_waitrequest = avs_read && !cur.readValid;
  assign avs_readdata = cur.readData;
  assign dmaRequest0 = chanOn[0] && !cur.pending[0]; // R18
  assign dmaRequest1 = chanOn[1] && !cur.pending[1]; // R18
  assign chan0Level = cur.level[0];
  assign chan1Level = cur.level[1];
  // Internal routing takes channel 0 off its pin
  assign internalRouteEnable = chanOn[0] && cur.ctrlA[dac_ctrl_pkg::BIT_INTERNAL_OUT]; // R6
  assign chan0PinEnable = chanOn[0] && cur.ctrlA[dac_ctrl_pkg::BIT_CH0_OUT] &&
    !cur.ctrlA[dac_ctrl_pkg::BIT_INTERNAL_OUT];
  assign chan1PinEnable = chanOn[1] && cur.ctrlA[dac_ctrl_pkg::BIT_CH1_OUT];
  assign referenceSelect = cur.refSel; // R9
  assign lowPowerSelect = cur.ctrlA[dac_ctrl_pkg::BIT_LOW_POWER];

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // A start loads the countdown; each later edge takes one off
  sequence s_conv_normal(c);
    startConv[c] && !cur.ctrlA[dac_ctrl_pkg::BIT_LOW_POWER] ##1
      cur.convCount[c] == dac_ctrl_pkg::CONV_NORMAL;
  endsequence
  sequence s_conv_low(c);
    startConv[c] && cur.ctrlA[dac_ctrl_pkg::BIT_LOW_POWER] ##1
      cur.convCount[c] == dac_ctrl_pkg::CONV_LOW;
  endsequence
  // A data write leaves the channel holding fresh data
  sequence s_data_write(c);
    dataWrite[c] ##1 cur.pending[c];
  endsequence

  // Conversion start
  a_auto_start: assert property (chanOn[0] && !cur.trigMode[0] && cur.pending[0] &&
      cur.convCount[0] == 5'h00 && !dataWrite[0] |-> startConv[0]) // R1
    else $error("untriggered channel 0 did not start");

  a_auto_start1: assert property (chanOn[1] && !cur.trigMode[1] && cur.pending[1] &&
      cur.convCount[1] == 5'h00 && !dataWrite[1] |-> startConv[1]) // R1
    else $error("untriggered channel 1 did not start");

  a_event_gate: assert property (startConv[1] && cur.trigMode[1] |-> chanEvent[1]) // R2
    else $error("triggered start without event");

  a_event_gate0: assert property (startConv[0] && cur.trigMode[0] |-> chanEvent[0]) // R2
    else $error("channel 0 triggered start without event");

  a_start_fresh: assert property (startConv[0] |-> cur.pending[0] ##1 !cur.pending[0]) // R2
    else $error("start without fresh data");

  a_start_fresh1: assert property (startConv[1] |-> cur.pending[1] ##1 !cur.pending[1]) // R2
    else $error("channel 1 start without fresh data");

  a_event_up: assert property (startConv[1] && cur.trigMode[1] &&
      cur.triggerEventSelect[3] |-> eventIn[3'(cur.triggerEventSelect[2:0] + 3'h1)]) // R19
    else $error("channel 1 took the wrong event");

  // A busy channel never restarts, so the two channels stay apart
  a_busy_block0: assert property (cur.convCount[0] != 5'h00 |-> !startConv[0]) // R4
    else $error("channel 0 restarted while busy");

  a_busy_block1: assert property (cur.convCount[1] != 5'h00 |-> !startConv[1]) // R4
    else $error("channel 1 restarted while busy");

  // Conversion length
  a_normal_time: assert property (startConv[0] && !lowPowerSelect |->
      ##1 cur.convCount[0] == dac_ctrl_pkg::CONV_NORMAL) // R8
    else $error("normal conversion length wrong");

  a_normal_time1: assert property (startConv[1] && !lowPowerSelect |->
      ##1 cur.convCount[1] == dac_ctrl_pkg::CONV_NORMAL) // R8
    else $error("channel 1 normal conversion length wrong");

  a_low_power_time: assert property (startConv[0] && lowPowerSelect |->
      ##1 cur.convCount[0] == dac_ctrl_pkg::CONV_LOW) // R8
    else $error("low power conversion length wrong");

  a_seq_normal: assert property (s_conv_normal(0) |-> ##9 cur.convCount[0] == 5'h01) // R8
    else $error("normal countdown broken");

  a_seq_low: assert property (s_conv_low(0) |-> ##19 cur.convCount[0] == 5'h01) // R8
    else $error("low power countdown broken");

  // Output levels
  a_level_hold: assert property (cur.convCount[0] != 5'h01 |=> $stable(chan0Level)) // R21
    else $error("channel 0 level changed outside completion");

  a_level_hold1: assert property (cur.convCount[1] != 5'h01 |=> $stable(chan1Level)) // R21
    else $error("channel 1 level changed outside completion");

  // Data empty flags
  a_write_pending: assert property (dataWrite[1] |=> cur.pending[1] && !dmaRequest1) // R18
    else $error("write did not clear data empty");

  a_write_pending0: assert property (dataWrite[0] |=> cur.pending[0] && !dmaRequest0) // R18
    else $error("channel 0 write did not clear data empty");

  a_pending_hold: assert property (s_data_write(0) |-> !dmaRequest0) // R18
    else $error("fresh data still asks for more");

  // Channel select decode
  a_channel_select_only0: assert property (cur.ctrlA[0] && cur.channelSelect == 2'h0 |->
      chanOn == 2'h1) // R17
    else $error("channel select decode wrong");

  a_channel_select_only1: assert property (cur.ctrlA[0] && cur.channelSelect == 2'h1 |->
      chanOn == 2'h2) // R17
    else $error("channel 1 select decode wrong");

  a_channel_select_dual: assert property (cur.ctrlA[0] && cur.channelSelect == 2'h2 |->
      chanOn == 2'h3) // R17
    else $error("dual select decode wrong");

  a_channel_select_reserved: assert property (cur.channelSelect == 2'h3 |->
      chanOn == 2'h0) // R17
    else $error("reserved select enabled a channel");

  a_disabled_quiet: assert property (!cur.ctrlA[dac_ctrl_pkg::BIT_ENABLE] |->
      !dmaRequest0 && !dmaRequest1 && !chan0PinEnable && !chan1PinEnable) // R17 R18
    else $error("disabled block still active");

  // Output routing
  a_route_pin: assert property (internalRouteEnable |-> !chan0PinEnable) // R6
    else $error("channel 0 on pin while routed inside");

  a_route_on: assert property (internalRouteEnable |-> chanOn[0]) // R6
    else $error("internal route without channel 0");

  a_pin1_on: assert property (chan1PinEnable |-> chanOn[1]) // R4
    else $error("channel 1 pin without channel 1");

  // Register bus
  a_read_answer: assert property (avs_read && !cur.readValid |=> !avs_waitrequest) // R7
    else $error("read not answered in one cycle");

  a_write_nowait: assert property (avs_write |-> !avs_waitrequest) // R16
    else $error("write was held off");

  a_readdata_stable: assert property (!(avs_read && !cur.readValid) |=>
      $stable(avs_readdata)) // R7
    else $error("read data moved without a read");

  a_ref_load: assert property (avs_write && avs_byteenable[0] &&
      wIdx == dac_ctrl_pkg::IDX_CTRL_C |=> referenceSelect == $past(avs_writedata[4:3])) // R9
    else $error("reference select not loaded");

  a_lp_load: assert property (avs_write && avs_byteenable[0] &&
      wIdx == dac_ctrl_pkg::IDX_CTRL_A |=> lowPowerSelect == $past(avs_writedata[1])) // R8
    else $error("low power select not loaded");

  // Full-word data writes land in the current alignment
  a_right_align: assert property (dataWrite[0] && !cur.leftAlign && avs_byteenable[1:0] == 2'h3
      |=> cur.sample[0] == $past(avs_writedata[11:0])) // R20 R3
    else $error("right aligned data not loaded");

  a_left_align: assert property (dataWrite[0] && cur.leftAlign && avs_byteenable[1:0] == 2'h3
      |=> cur.sample[0] == $past(avs_writedata[15:4])) // R20
    else $error("left aligned data not loaded");
endmodule

// File: tb/dac_load_model.sv
// Purpose: analog side of the converter: output drivers into a load
// Assumes: ideal linear driver, voltages in whole millivolts
// Notes: the load pulls a released pin to 0 mV
`timescale 1ns/1ps
module dac_load_model #(
  parameter int SUPPLY_MV = 3300,
  parameter int PIN_A_MV = 2000,
  parameter int PIN_B_MV = 2500
) (
  // Converter side
  input wire logic [11:0] chan0Level,
  input wire logic [11:0] chan1Level,
  input wire logic chan0PinEnable,
  input wire logic chan1PinEnable,
  input wire logic internalRouteEnable,
  input wire logic [1:0] referenceSelect,
  // Measured voltages
  output int pin0Mv,
  output int pin1Mv,
  output int internalMv
);
  int refMv;
  always_comb begin
    case (referenceSelect)
      2'h0: refMv = 32'h3E8;
      2'h1: refMv = SUPPLY_MV;
      2'h2: refMv = PIN_A_MV;
      default: refMv = PIN_B_MV;
    endcase
    // Internal route takes channel 0 off its pin
    pin0Mv = (chan0PinEnable && !internalRouteEnable) ? chan0Level * refMv / 32'hFFF : 0;
    pin1Mv = chan1PinEnable ? chan1Level * refMv / 32'hFFF : 0;
    internalMv = internalRouteEnable ? chan0Level * refMv / 32'hFFF : 0;
  end
endmodule

// File: tb/dac_ctrl_tb.sv
// Purpose: self-checking bench for dac_ctrl
// Assumes: bus tasks start and end on a rising edge
// Notes: levels are watched at falling edges, where they are settled
`timescale 1ns/1ps
module dac_ctrl_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] eventIn = 8'h00;
  logic dmaRequest0, dmaRequest1, chan0PinEnable, chan1PinEnable;
  logic internalRouteEnable, lowPowerSelect;
  logic [11:0] chan0Level, chan1Level;
  logic [1:0] referenceSelect;
  int pin0Mv, pin1Mv, internalMv, errorCnt = 0, testsRun = 0, n;
  logic [31:0] d;
  dac_ctrl i_dac_ctrl (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .eventIn(eventIn), .dmaRequest0(dmaRequest0),
    .dmaRequest1(dmaRequest1), .chan0Level(chan0Level), .chan1Level(chan1Level),
    .chan0PinEnable(chan0PinEnable), .chan1PinEnable(chan1PinEnable),
    .internalRouteEnable(internalRouteEnable), .referenceSelect(referenceSelect),
    .lowPowerSelect(lowPowerSelect));
  dac_load_model i_dac_load_model (.chan0Level(chan0Level), .chan1Level(chan1Level),
    .chan0PinEnable(chan0PinEnable), .chan1PinEnable(chan1PinEnable),
    .internalRouteEnable(internalRouteEnable), .referenceSelect(referenceSelect),
    .pin0Mv(pin0Mv), .pin1Mv(pin1Mv), .internalMv(internalMv));
  initial forever #50 sys_clk = ~sys_clk;
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for waitrequest low; returns on that rising edge
  task automatic waitAns();
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) return;
    end
    errorCnt++;
    end_sim();
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] v);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= v;
    avs_write <= 1'b1;
    waitAns();
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] idx, output logic [31:0] v);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= 1'b1;
    waitAns();
    v = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic pulse(input int b);
    @(posedge sys_clk);
    eventIn <= 8'h01 << b;
    @(posedge sys_clk);
    eventIn <= 8'h00;
  endtask
  // Falling edges until the level moves, at most lim
  task automatic lvl(input bit ch, input int lim, output int k);
    logic [11:0] old;
    old = ch ? chan1Level : chan0Level;
    for (k = 0; k < lim; k++) begin
      @(negedge sys_clk);
      if ((ch ? chan1Level : chan0Level) !== old) return;
    end
  endtask
  task automatic t_reset();
    rd(dac_ctrl_pkg::IDX_CTRL_A, d);
    chk(d, 32'h0);
    rd(dac_ctrl_pkg::IDX_STATUS, d);
    chk(d, 32'h0);
    wr(4'h4, 32'hFF);
    rd(4'h4, d);
    chk(d, 32'h0);
  endtask
  task automatic t_auto();
    wr(dac_ctrl_pkg::IDX_CTRL_A, 32'h05);
    wr(dac_ctrl_pkg::IDX_CHAN0_DATA, 32'hFFF);
    @(negedge sys_clk);
    chk(dmaRequest0, 1'b0);
    lvl(0, 40, n);
    chk(n, 32'hA);
    chk(chan0Level, 32'hFFF);
    chk(pin0Mv, 32'h3E8);
    chk(chan1Level, 32'h0);
    chk({dmaRequest0, chan0PinEnable}, 2'h3);
    lvl(0, 15, n);
    chk(n, 32'hF);
  endtask
  task automatic t_lowpow();
    wr(dac_ctrl_pkg::IDX_CTRL_A, 32'h07);
    wr(dac_ctrl_pkg::IDX_CHAN0_DATA, 32'h123);
    lvl(0, 40, n);
    chk(n, 32'h15);
    chk({lowPowerSelect, chan0Level}, 13'h1123);
  endtask
  task automatic t_trig();
    wr(dac_ctrl_pkg::IDX_CTRL_A, 32'h09);
    wr(dac_ctrl_pkg::IDX_CTRL_B, 32'h43);
    wr(dac_ctrl_pkg::IDX_EVENT_CTRL, 32'h0B);
    wr(dac_ctrl_pkg::IDX_CHAN1_DATA, 32'h456);
    lvl(1, 15, n);
    chk(n, 32'hF);
    pulse(3);
    lvl(1, 15, n);
    chk(n, 32'hF);
    pulse(4);
    lvl(1, 40, n);
    chk({pin1Mv != 0, chan1Level}, 13'h1456);
    wr(dac_ctrl_pkg::IDX_CHAN0_DATA, 32'h321);
    pulse(3);
    lvl(0, 40, n);
    chk(chan0Level, 32'h321);
  endtask
  // Fixed trims applied in the same setup as the channel 0 conversion that follows
  task automatic t_trim();
    logic [7:0] ofs [6] = '{8'h85, 8'h05, 8'h82, 8'h00, 8'h00, 8'h00};
    logic [7:0] gn [6] = '{8'h00, 8'h00, 8'h40, 8'hC0, 8'h00, 8'h00};
    logic [15:0] v [6] = '{16'h0800, 16'h0800, 16'h0C00, 16'h0C00, 16'h0FFF, 16'hABC0};
    logic [11:0] e [6] = '{12'h805, 12'h7FB, 12'hC42, 12'hBC0, 12'hFFF, 12'hABC};
    wr(dac_ctrl_pkg::IDX_CTRL_B, 32'h00);
    wr(dac_ctrl_pkg::IDX_CTRL_A, 32'h05);
    for (int i = 0; i < 6; i++) begin
      wr(dac_ctrl_pkg::IDX_OFFSET_TRIM, {24'h0, ofs[i]});
      wr(dac_ctrl_pkg::IDX_GAIN_TRIM, {24'h0, gn[i]});
      wr(dac_ctrl_pkg::IDX_CTRL_C, (i == 5) ? 32'h1 : 32'h0);
      wr(dac_ctrl_pkg::IDX_CHAN0_DATA, {16'h0, v[i]});
      lvl(0, 40, n);
      chk(chan0Level, e[i]);
    end
  endtask
  task automatic t_sel();
    logic [1:0] e [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    wr(dac_ctrl_pkg::IDX_CTRL_A, 32'h15);
    @(negedge sys_clk);
    chk(pin0Mv, 32'h0);
    chk(internalMv, 32'hABC * 32'h3E8 / 32'hFFF);
    for (int s = 0; s < 4; s++) begin
      wr(dac_ctrl_pkg::IDX_CTRL_B, 32'(s) << 5);
      rd(dac_ctrl_pkg::IDX_STATUS, d);
      chk(d, {30'h0, e[s]});
      chk({dmaRequest1, dmaRequest0}, e[s]);
      wr(dac_ctrl_pkg::IDX_CTRL_C, 32'(s) << 3);
      @(negedge sys_clk);
      chk(referenceSelect, s[1:0]);
    end
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_auto();
    t_lowpow();
    t_trig();
    t_trim();
    t_sel();
    end_sim();
  end
endmodule
